// ===== uart_pins_pkg.sv
// Package for the host-facing pin logic of one UART channel.
// Assumes a single core clock; shared by the pin block and its test bench.
package uart_pins_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned CHAN_N = 4;
    localparam int unsigned SRC_N = 4;

    // Modem control register layout
    localparam int unsigned MCR_TERM_READY_BIT = 0;
    localparam int unsigned MCR_IRQ_OE_BIT = 3;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] IER_RST = 8'h00;

    // Register select codes inside this block
    localparam logic [2:0] SEL_IER = 3'h1;
    localparam logic [2:0] SEL_MCR = 3'h4;

    // Interrupt source positions
    localparam int unsigned SRC_RX_DATA = 0;
    localparam int unsigned SRC_TX_EMPTY = 1;
    localparam int unsigned SRC_RX_ERR = 2;
    localparam int unsigned SRC_MODEM = 3;

    // Tie-off choice for parts without a select pin
    typedef enum logic [1:0]
    {
        SEL_PIN = 2'b00,
        SEL_TIE_HIGH = 2'b01,
        SEL_TIE_LOW = 2'b10
    } irq_sel_src_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } bus_state_t;

    typedef struct packed
    {
        logic [2:0] sel;
        logic cs_n;
        logic rd_n;
        logic wr_n;
    } bus_ctl_t;

    typedef struct packed
    {
        bus_state_t st;
        logic [7:0] modem_control_reg;
        logic [7:0] irq_enable_reg;
        logic [7:0] rd_data;
        logic [7:0] line_tx;
        logic line_tx_valid;
        logic [3:0] irq;
        logic [3:0] irq_oe;
        logic term_ready_n;
        logic modem_ready;
    } pin_state_t;

endpackage

// ===== uart_host_pins.sv
// Host pins of one UART channel: data bus, strobes, interrupt pins, terminal/modem ready.
// Assumes strobes and address are synchronous to core_clk; the core supplies
// register read data, pending interrupt sources and takes the serial byte lane.
module uart_host_pins #(
    parameter uart_pins_pkg::irq_sel_src_t SEL_SRC = uart_pins_pkg::SEL_PIN
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Bus mode: high selects strobe style
    input wire logic strobe_mode,
    // Host bus
    input wire logic [2:0] reg_select_bits,
    input wire logic channel_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    // Core register read data for the addressed register
    input wire logic [7:0] core_rd_data,
    // Per-channel pending interrupt sources
    input wire logic [3:0][3:0] irq_pending,
    // Interrupt select pin, pulled low when floating
    input wire logic irq_force_select,
    output logic [3:0] channel_irq_out,
    output logic [3:0] channel_irq_oe,
    // Modem lines
    input wire logic modem_ready_in,
    output logic terminal_ready_out,
    output logic modem_ready_status,
    // Serial byte lane toward the core
    output logic [7:0] line_tx_byte,
    output logic line_tx_valid,
    output logic line_enable
);

    uart_pins_pkg::pin_state_t state_ff;
    uart_pins_pkg::pin_state_t nxt_state;
    uart_pins_pkg::bus_ctl_t bus;
    logic sel_eff;
    logic rd_req;
    logic wr_req;
    logic [3:0] irq_raw;
    logic [3:0] oe_eff;

    assign bus = '{sel: reg_select_bits, cs_n: channel_select_n,
                   rd_n: read_strobe_n, wr_n: write_strobe_n};

    // Floating pin reads low thanks to the pull-down outside
    always_comb
    begin
        unique case (SEL_SRC)
            uart_pins_pkg::SEL_TIE_HIGH: sel_eff = 1'b1;
            uart_pins_pkg::SEL_TIE_LOW: sel_eff = 1'b0;
            default: sel_eff = irq_force_select;
        endcase
    end

    assign rd_req = strobe_mode && !bus.cs_n && !bus.rd_n;
    assign wr_req = strobe_mode && !bus.cs_n && !bus.wr_n;

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_irq
            // Same enable register for all channels in this block
            assign irq_raw[ch] = |(irq_pending[ch] & state_ff.irq_enable_reg[3:0]);
            assign oe_eff[ch] = strobe_mode
                && (sel_eff || state_ff.modem_control_reg[uart_pins_pkg::MCR_IRQ_OE_BIT]);
            // Each pin checked on its own so a crossed channel shows up
            irq_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
                channel_irq_out[ch] |-> $past(|(irq_pending[ch] & state_ff.irq_enable_reg[3:0])))
                else $error("interrupt without enabled source");
            irq_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
                |(irq_pending[ch] & state_ff.irq_enable_reg[3:0]) |=> channel_irq_out[ch])
                else $error("enabled interrupt not raised");
        end
    endgenerate

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.line_tx_valid = 1'b0;
        nxt_state.modem_ready = !modem_ready_in;
        unique case (state_ff.st)
            uart_pins_pkg::ST_IDLE:
            begin
                if (rd_req)
                begin
                    nxt_state.st = uart_pins_pkg::ST_READ;
                    nxt_state.rd_data = core_rd_data;
                end
                else if (wr_req)
                begin
                    nxt_state.st = uart_pins_pkg::ST_WRITE;
                    if (bus.sel == uart_pins_pkg::SEL_MCR)
                        nxt_state.modem_control_reg = host_data_bus_in;
                    else if (bus.sel == uart_pins_pkg::SEL_IER)
                        nxt_state.irq_enable_reg = host_data_bus_in;
                    else
                    begin
                        // Bit 0 leads on the line
                        nxt_state.line_tx = host_data_bus_in;
                        nxt_state.line_tx_valid = 1'b1;
                    end
                end
            end
            uart_pins_pkg::ST_READ:
            begin
                nxt_state.rd_data = core_rd_data;
                if (!rd_req)
                    nxt_state.st = uart_pins_pkg::ST_IDLE;
            end
            uart_pins_pkg::ST_WRITE:
            begin
                // One store per strobe edge
                if (!wr_req)
                    nxt_state.st = uart_pins_pkg::ST_IDLE;
            end
            default:
            begin
                // Stray code: fall back to idle rather than lock the bus
                nxt_state.st = uart_pins_pkg::ST_IDLE;
            end
        endcase
        nxt_state.term_ready_n = !nxt_state.modem_control_reg[uart_pins_pkg::MCR_TERM_READY_BIT];
        nxt_state.irq = irq_raw;
        nxt_state.irq_oe = oe_eff;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= '{st: uart_pins_pkg::ST_IDLE, modem_control_reg: uart_pins_pkg::MCR_RST,
                          irq_enable_reg: uart_pins_pkg::IER_RST, rd_data: 8'h00, line_tx: 8'h00,
                          line_tx_valid: 1'b0, irq: 4'h0, irq_oe: 4'h0,
                          term_ready_n: 1'b1, modem_ready: 1'b0};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign host_data_bus_out = state_ff.rd_data;
    // Driven only while the read is held; strobe release floats at once
    assign host_data_bus_oe = rd_req && state_ff.st == uart_pins_pkg::ST_READ;
    assign channel_irq_out = state_ff.irq;
    assign channel_irq_oe = state_ff.irq_oe;
    assign terminal_ready_out = state_ff.term_ready_n;
    assign modem_ready_status = state_ff.modem_ready;
    assign line_tx_byte = state_ff.line_tx;
    assign line_tx_valid = state_ff.line_tx_valid;
    assign line_enable = !sys_rst;

    // Assertions
    sequence rd_held_s;
        rd_req ##1 rd_req;
    endsequence

    data_bus_float_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(rd_req && $past(rd_req)) |-> !host_data_bus_oe)
        else $error("data bus driven outside a read");
    data_bus_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rd_held_s |-> host_data_bus_oe && host_data_bus_out == $past(core_rd_data))
        else $error("read data not presented");
    term_ready_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_req && state_ff.st == uart_pins_pkg::ST_IDLE && bus.sel == uart_pins_pkg::SEL_MCR
        && host_data_bus_in[0] |=> !terminal_ready_out)
        else $error("terminal ready not low after set");
    term_ready_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_req && state_ff.st == uart_pins_pkg::ST_IDLE && bus.sel == uart_pins_pkg::SEL_MCR
        && !host_data_bus_in[0] |=> terminal_ready_out)
        else $error("terminal ready not high after clear");
    irq_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (irq_raw == 4'h0) [*2] |-> channel_irq_out == 4'h0)
        else $error("interrupt held without source");
    irq_force_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        strobe_mode && sel_eff |=> channel_irq_oe == 4'hf || !$past(strobe_mode))
        else $error("forced interrupt enable missing");
    irq_mcr_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !sel_eff && !state_ff.modem_control_reg[uart_pins_pkg::MCR_IRQ_OE_BIT] ##1
        !state_ff.modem_control_reg[uart_pins_pkg::MCR_IRQ_OE_BIT] |-> channel_irq_oe == 4'h0)
        else $error("interrupt driven while disabled");
    mode_ignore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !strobe_mode |=> $stable(state_ff.modem_control_reg) && !host_data_bus_oe)
        else $error("strobe honoured in read/write mode");
    select_ignored_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !strobe_mode |=> channel_irq_oe == 4'h0)
        else $error("interrupt enable driven in read/write mode");
    // Status register holds its reset value for one edge after release
    modem_status_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> modem_ready_status == !$past(modem_ready_in))
        else $error("modem ready status not tracking pin");
    // Line lane: one pulse per accepted write to a select other than MCR or IER, carrying the bus as it was
    line_byte_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        line_tx_valid |-> line_tx_byte == $past(host_data_bus_in))
        else $error("line byte not the written bus value");
    line_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        line_tx_valid |=> !line_tx_valid)
        else $error("line byte stored twice for one strobe");

endmodule

// ===== host_cpu_model.sv
// Controlling CPU on the strobe-style host bus of one channel.
// Assumes the block samples strobes on core_clk.
module host_cpu_model (
    // Clock
    input wire logic core_clk,
    // Bus toward the block
    input wire logic host_data_bus_oe,
    input wire logic [7:0] host_data_bus_out,
    output logic [2:0] reg_select_bits,
    output logic channel_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [7:0] host_data_bus_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cpu_d = 8'h00;
    // Released bus shows the inverse, so a stale copy never passes
    assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : cpu_d;
    initial
    begin
        reg_select_bits = 3'h0;
        channel_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_select_bits <= a;
        cpu_d <= d;
        channel_select_n <= 1'b0;
        write_strobe_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        channel_select_n <= 1'b1;
        write_strobe_n <= 1'b1;
        cpu_d <= ~d;
        @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(posedge core_clk);
        reg_select_bits <= a;
        channel_select_n <= 1'b0;
        read_strobe_n <= 1'b0;
        for (n = 0; n < 6 && !ok; n++)
        begin
            @(posedge core_clk);
            #1;
            ok = host_data_bus_oe === 1'b1;
        end
        d = host_data_bus_in;
        @(posedge core_clk);
        channel_select_n <= 1'b1;
        read_strobe_n <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask
endmodule

// ===== quad_uart_host_pins_irq_test.sv
// Self-checking bench for the channel host pins.
// Assumes host_cpu_model drives the bus; core side driven here.
module quad_uart_host_pins_irq_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, sys_rst = 1'b1, strobe_mode = 1'b1;
    logic irq_force_select = 1'b0, modem_ready_in = 1'b1, ok;
    logic [7:0] core_rd_data = 8'h00, tx_seen = 8'h00, rd_v;
    logic [3:0][3:0] irq_pending = 16'h0000;
    logic [2:0] sel;
    logic cs_n, rd_n, wr_n, bus_oe, trm, mrs, txv, len;
    logic [7:0] bus_in, bus_out, txb;
    logic [3:0] irq, irq_oe, tie_hi_oe, tie_lo_oe;
    int error_cnt = 0, cmp_count = 0, i, tx_cnt = 0;
    uart_host_pins i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .strobe_mode(strobe_mode),
        .reg_select_bits(sel), .channel_select_n(cs_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
        .host_data_bus_oe(bus_oe), .core_rd_data(core_rd_data), .irq_pending(irq_pending),
        .irq_force_select(irq_force_select), .channel_irq_out(irq), .channel_irq_oe(irq_oe),
        .modem_ready_in(modem_ready_in), .terminal_ready_out(trm), .modem_ready_status(mrs),
        .line_tx_byte(txb), .line_tx_valid(txv), .line_enable(len));
    host_cpu_model i_cpu (.core_clk(core_clk), .host_data_bus_oe(bus_oe),
        .host_data_bus_out(bus_out), .reg_select_bits(sel), .channel_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .host_data_bus_in(bus_in));
    // Tie-off builds share every input; only their irq enables are watched
    uart_host_pins #(.SEL_SRC(uart_pins_pkg::SEL_TIE_HIGH)) i_dut_hi (.core_clk(core_clk),
        .sys_rst(sys_rst), .strobe_mode(strobe_mode), .reg_select_bits(sel),
        .channel_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .host_data_bus_in(bus_in), .host_data_bus_out(), .host_data_bus_oe(),
        .core_rd_data(core_rd_data), .irq_pending(irq_pending),
        .irq_force_select(irq_force_select), .channel_irq_out(), .channel_irq_oe(tie_hi_oe),
        .modem_ready_in(modem_ready_in), .terminal_ready_out(), .modem_ready_status(),
        .line_tx_byte(), .line_tx_valid(), .line_enable());
    uart_host_pins #(.SEL_SRC(uart_pins_pkg::SEL_TIE_LOW)) i_dut_lo (.core_clk(core_clk),
        .sys_rst(sys_rst), .strobe_mode(strobe_mode), .reg_select_bits(sel),
        .channel_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .host_data_bus_in(bus_in), .host_data_bus_out(), .host_data_bus_oe(),
        .core_rd_data(core_rd_data), .irq_pending(irq_pending),
        .irq_force_select(irq_force_select), .channel_irq_out(), .channel_irq_oe(tie_lo_oe),
        .modem_ready_in(modem_ready_in), .terminal_ready_out(), .modem_ready_status(),
        .line_tx_byte(), .line_tx_valid(), .line_enable());
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (txv === 1'b1)
        begin
            tx_seen <= txb;
            tx_cnt <= tx_cnt + 1;
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Irq pins are registered; three edges covers both latency stages
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    initial
    begin
        #100000;
        error_cnt++;
        final_report();
    end
    initial
    begin
        settle();
        chk("trm_rst", 8'(trm), 8'h01);
        chk("len_rst", 8'(len), 8'h00);
        chk("oe_rst", 8'(irq_oe), 8'h00);
        repeat (13) @(posedge core_clk);
        sys_rst <= 1'b0;
        core_rd_data <= 8'ha5;
        settle();
        chk("len", 8'(len), 8'h01);
        i_cpu.rd(3'h3, rd_v, ok);
        chk("rd_ok", 8'(ok), 8'h01);
        chk("rd_data", rd_v, 8'ha5);
        chk("bus_idle", 8'(bus_oe), 8'h00);
        i_cpu.wr(3'h4, 8'h01);
        chk("trm_on", 8'(trm), 8'h00);
        @(posedge core_clk);
        modem_ready_in <= 1'b0;
        settle();
        chk("mrs", 8'(mrs), 8'h01);
        chk("trm_keep", 8'(trm), 8'h00);
        i_cpu.wr(3'h4, 8'h00);
        chk("trm_off", 8'(trm), 8'h01);
        @(posedge core_clk);
        strobe_mode <= 1'b0;
        irq_force_select <= 1'b1;
        i_cpu.rd(3'h3, rd_v, ok);
        chk("rd_refused", 8'(ok), 8'h00);
        chk("oe_rw", 8'(irq_oe), 8'h00);
        chk("oe_rw_hi", 8'(tie_hi_oe), 8'h00);
        @(posedge core_clk);
        strobe_mode <= 1'b1;
        settle();
        chk("oe_force", 8'(irq_oe), 8'h0f);
        chk("oe_tie_lo", 8'(tie_lo_oe), 8'h00);
        @(posedge core_clk);
        irq_force_select <= 1'b0;
        settle();
        chk("oe_off", 8'(irq_oe), 8'h00);
        chk("oe_tie_hi", 8'(tie_hi_oe), 8'h0f);
        i_cpu.wr(3'h4, 8'h08);
        settle();
        chk("oe_on", 8'(irq_oe), 8'h0f);
        chk("oe_tie_lo_on", 8'(tie_lo_oe), 8'h0f);
        for (i = 0; i < 4; i++)
        begin
            i_cpu.wr(3'h1, 8'h01 << i);
            @(posedge core_clk);
            irq_pending[2] <= 4'h1 << i;
            settle();
            chk("irq_src", 8'(irq), 8'h04);
            @(posedge core_clk);
            irq_pending[2] <= 4'h0;
            settle();
            chk("irq_clr", 8'(irq), 8'h00);
        end
        i_cpu.wr(3'h1, 8'h0e);
        @(posedge core_clk);
        irq_pending[1] <= 4'h1;
        settle();
        chk("irq_masked", 8'(irq), 8'h00);
        i_cpu.wr(3'h2, 8'h5a);
        settle();
        chk("tx_byte", tx_seen, 8'h5a);
        chk("tx_count", 8'(tx_cnt), 8'h01);
        // Mid-run reset must undo both control registers
        i_cpu.wr(3'h1, 8'h01);
        settle();
        chk("irq_pre", 8'(irq), 8'h02);
        i_cpu.wr(3'h4, 8'h09);
        chk("trm_pre", 8'(trm), 8'h00);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        settle();
        chk("trm_rst2", 8'(trm), 8'h01);
        chk("len_rst2", 8'(len), 8'h00);
        chk("oe_rst2", 8'(irq_oe), 8'h00);
        chk("irq_rst2", 8'(irq), 8'h00);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        settle();
        chk("trm_after", 8'(trm), 8'h01);
        chk("oe_after", 8'(irq_oe), 8'h00);
        chk("irq_after", 8'(irq), 8'h00);
        final_report();
    end
endmodule
